// file: rtl/rcal_params.svh
// Constants for the calendar and alarm set-point register block.
// Assumes inclusion by the package, the alarm and register modules and the bench.
`ifndef RCAL_PARAMS_SVH
`define RCAL_PARAMS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define RCAL_IDX_MONTH 8'he5
`define RCAL_IDX_YEAR 8'he6
`define RCAL_IDX_HUNDRED 8'he7
`define RCAL_IDX_WAKE_SEC 8'he8
`define RCAL_IDX_WAKE_MIN 8'he9
`define RCAL_IDX_WAKE_HOUR 8'hea
`define RCAL_IDX_CTRL 8'hf0
`define RCAL_IDX_MATCH_EN 8'hf1

// ****************************************************************
// Address layout on the 12-bit APB address
// ****************************************************************
`define RCAL_ADDR_W 12
`define RCAL_IDX_HI 9
`define RCAL_IDX_LO 2

// ****************************************************************
// Field positions
// ****************************************************************
`define RCAL_CTRL_UNLOCK 0
`define RCAL_CTRL_DECIMAL 1
`define RCAL_EN_SECOND 0
`define RCAL_EN_MINUTE 1
`define RCAL_EN_HOUR 2

// ****************************************************************
// Count ranges, held as plain binary values
// ****************************************************************
`define RCAL_MONTH_FIRST 8'h01
`define RCAL_MONTH_LAST 8'h0c
`define RCAL_YEAR_FIRST 8'h00
`define RCAL_YEAR_LAST 8'h63
`define RCAL_HUNDRED_FIRST 8'h00
`define RCAL_HUNDRED_LAST 8'h63

// ****************************************************************
// Reset values of the control fields
// ****************************************************************
`define RCAL_RST_ENABLES 3'h0
`define RCAL_RST_UNLOCK 1'b0
`define RCAL_RST_DECIMAL 1'b0

`endif

// file: rtl/rcal_pkg.sv
// Types and shared arithmetic for the calendar and alarm register block.
// Assumes rcal_params.svh is on the include path.
`include "rcal_params.svh"

package rcal_pkg;

    // ****************************************************************
    // Bus handshake phase
    // ****************************************************************
    typedef enum logic [1:0] {
        RCAL_BUS_IDLE = 2'b00,
        RCAL_BUS_DONE = 2'b01
    } rcal_bus_e;

    // ****************************************************************
    // Whole state of the top module
    // ****************************************************************
    typedef struct packed {
        rcal_bus_e bus;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] month;
        logic [7:0] year;
        logic [7:0] hundred;
        logic [7:0] wake_second;
        logic [7:0] wake_minute;
        logic [7:0] wake_hour;
        logic unlock;
        logic decimal;
        logic [2:0] match_enable;
    } rcal_state_s;

    // ****************************************************************
    // Encoding helpers
    // ****************************************************************
    // Binary 0..99 to two packed decimal digits
    function automatic logic [7:0] rcal_encode(input logic [7:0] bin, input logic decimal);
        logic [3:0] tens;
        logic [3:0] ones;
        tens = 4'(bin / 8'h0a);
        ones = 4'(bin % 8'h0a);
        rcal_encode = decimal ? {tens, ones} : bin;
    endfunction : rcal_encode

    // Add one in the selected encoding, carrying the ones digit at nine
    function automatic logic [7:0] rcal_add_one(input logic [7:0] value, input logic decimal);
        if (decimal && value[3:0] >= 4'h9) begin
            rcal_add_one = {4'(value[7:4] + 4'h1), 4'h0};
        end else begin
            rcal_add_one = 8'(value + 8'h01);
        end
    endfunction : rcal_add_one

endpackage : rcal_pkg

// file: rtl/rcal_count_step.sv
// One calendar counter stage: next value and wrap flag.
// Assumes the caller applies the step only on its carry-in.
`timescale 1ns/1ps

module rcal_count_step
    import rcal_pkg::*;
(
    // Present count
    input wire logic [7:0] value,
    input wire logic decimal,
    // Range in plain binary
    input wire logic [7:0] first,
    input wire logic [7:0] last,
    // Result
    output logic [7:0] next_value,
    output logic at_last
);

    always_comb begin
        // Wrap back to the first value in the selected encoding
        at_last = (value == rcal_encode(last, decimal));
        if (at_last) begin
            next_value = rcal_encode(first, decimal);
        end else begin
            next_value = rcal_add_one(value, decimal);
        end
    end

endmodule : rcal_count_step

// file: rtl/rcal_alarm_cmp.sv
// Alarm comparison of the time-of-day set-points against current counts.
// Assumes count_tick pulses once for every count increment.
`timescale 1ns/1ps
`include "rcal_params.svh"

module rcal_alarm_cmp
    import rcal_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Evaluation strobe
    input wire logic count_tick,
    // Set-points and enables
    input wire logic [7:0] wake_second,
    input wire logic [7:0] wake_minute,
    input wire logic [7:0] wake_hour,
    input wire logic [2:0] match_enable,
    // Current counts
    input wire logic [7:0] now_second,
    input wire logic [7:0] now_minute,
    input wire logic [7:0] now_hour,
    // Result
    output logic alarm_match
);

    typedef struct packed {
        logic hit;
    } rcal_cmp_s;

    rcal_cmp_s s;
    rcal_cmp_s n;

    always_comb begin
        logic sec_ok;
        logic min_ok;
        logic hour_ok;
        sec_ok = 1'b0;
        min_ok = 1'b0;
        hour_ok = 1'b0;
        n = s;
        // Disabled fields never block a match
        sec_ok = !match_enable[`RCAL_EN_SECOND] || (wake_second == now_second);
        min_ok = !match_enable[`RCAL_EN_MINUTE] || (wake_minute == now_minute);
        hour_ok = !match_enable[`RCAL_EN_HOUR] || (wake_hour == now_hour);
        // With nothing enabled there is no alarm at all
        n.hit = count_tick && (match_enable != 3'h0) && sec_ok && min_ok && hour_ok;
        if (rst) begin
            n.hit = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        s <= n;
    end

    assign alarm_match = s.hit;

endmodule : rcal_alarm_cmp

// file: rtl/rcal_regs.sv
// Calendar (month, year, hundred-year) count registers and alarm
// set-points behind an APB slave.
// Assumes the time-of-day counters sit outside and supply the month
// carry, the count tick and the current second, minute and hour fields.
// Reset spares counts and set-points.
// Low byte lane only.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "rcal_params.svh"

module rcal_regs
    import rcal_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`RCAL_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // From the time-of-day counters
    input wire logic month_carry,
    input wire logic count_tick,
    input wire logic [7:0] now_second,
    input wire logic [7:0] now_minute,
    input wire logic [7:0] now_hour,
    // To the rest of the clock
    output logic decimal_mode,
    output logic clock_unlock,
    output logic [2:0] match_enable,
    output logic [7:0] month_value,
    output logic [7:0] year_value,
    output logic [7:0] hundred_value,
    output logic alarm_match
);

    // ****************************************************************
    // State
    // ****************************************************************
    rcal_state_s s;
    rcal_state_s n;
    // n: next copy of s
    // taken whole each edge

    // Stage outputs
    logic [7:0] month_step;
    logic [7:0] year_step;
    logic [7:0] hundred_step;
    logic month_at_last;
    logic year_at_last;
    logic hundred_at_last;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // One register per word
    // f0: unlock, decimal
    // f1: match enables
    // Any address with bits outside the index field is unmapped
    function automatic logic rcal_mapped(input logic [`RCAL_ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = addr[`RCAL_IDX_HI:`RCAL_IDX_LO];
        // Lane and top bits zero
        rcal_mapped = (addr[`RCAL_IDX_LO-1:0] == 2'h0)
            && (addr[`RCAL_ADDR_W-1:`RCAL_IDX_HI+1] == 2'h0)
            && ((idx >= `RCAL_IDX_MONTH && idx <= `RCAL_IDX_WAKE_HOUR)
            || idx == `RCAL_IDX_CTRL || idx == `RCAL_IDX_MATCH_EN);
    endfunction : rcal_mapped

    // Read mux
    function automatic logic [7:0] rcal_read(input rcal_state_s st, input logic [7:0] idx);
        logic [7:0] ctrl;
        // Control byte
        ctrl = 8'h00;
        ctrl[`RCAL_CTRL_UNLOCK] = st.unlock;
        ctrl[`RCAL_CTRL_DECIMAL] = st.decimal;
        case (idx)
            `RCAL_IDX_MONTH: begin
                rcal_read = st.month;
            end
            `RCAL_IDX_YEAR: begin
                rcal_read = st.year;
            end
            `RCAL_IDX_HUNDRED: begin
                rcal_read = st.hundred;
            end
            `RCAL_IDX_WAKE_SEC: begin
                rcal_read = st.wake_second;
            end
            `RCAL_IDX_WAKE_MIN: begin
                rcal_read = st.wake_minute;
            end
            `RCAL_IDX_WAKE_HOUR: begin
                rcal_read = st.wake_hour;
            end
            `RCAL_IDX_CTRL: begin
                rcal_read = ctrl;
            end
            `RCAL_IDX_MATCH_EN: begin
                rcal_read = {5'h00, st.match_enable};
            end
            default: begin
                rcal_read = 8'h00;
            end
        endcase
    endfunction : rcal_read

    // ****************************************************************
    // Calendar counter stages
    // ****************************************************************
    // Stages only propose;
    // a software write
    // may still win
    rcal_count_step u_month_step (
        .value(s.month),
        .decimal(s.decimal),
        .first(`RCAL_MONTH_FIRST),
        .last(`RCAL_MONTH_LAST),
        .next_value(month_step),
        .at_last(month_at_last)
    );

    rcal_count_step u_year_step (
        .value(s.year),
        .decimal(s.decimal),
        .first(`RCAL_YEAR_FIRST),
        .last(`RCAL_YEAR_LAST),
        .next_value(year_step),
        .at_last(year_at_last)
    );

    rcal_count_step u_hundred_step (
        .value(s.hundred),
        .decimal(s.decimal),
        .first(`RCAL_HUNDRED_FIRST),
        .last(`RCAL_HUNDRED_LAST),
        .next_value(hundred_step),
        .at_last(hundred_at_last)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic access;
        logic [7:0] idx;
        logic commit;
        logic year_carry;
        logic hundred_carry;
        access = psel && penable;
        idx = paddr[`RCAL_IDX_HI:`RCAL_IDX_LO];
        commit = 1'b0;
        year_carry = 1'b0;
        hundred_carry = 1'b0;
        n = s;

        // Day->month->year->hundreds
        // Calendar roll-over; the step module applies the active encoding
        if (month_carry) begin
            n.month = month_step;
            year_carry = month_at_last;
        end
        // Only on a month wrap
        if (year_carry) begin
            n.year = year_step;
            hundred_carry = year_at_last;
        end
        // Only on a year wrap
        if (hundred_carry) begin
            n.hundred = hundred_step;
        end
        // The top of the hundreds count has nowhere to carry to
        if (hundred_at_last && hundred_carry) begin
            n.hundred = hundred_step;
        end

        // IDLE takes the access,
        // DONE shows pready
        // One wait state; the write commits at the edge pready is seen high
        case (s.bus)
            RCAL_BUS_IDLE: begin
                // One-cycle pulses
                n.pready = 1'b0;
                n.pslverr = 1'b0;
                if (access) begin
                    n.pready = 1'b1;
                    n.pslverr = !rcal_mapped(paddr);
                    n.prdata = rcal_mapped(paddr) ? {24'h00_0000, rcal_read(s, idx)}
                        : 32'h0000_0000;
                    n.bus = RCAL_BUS_DONE;
                end
            end
            // Next setup may follow
            RCAL_BUS_DONE: begin
                // Mapped only
                commit = access && pwrite && !s.pslverr;
                n.pready = 1'b0;
                n.pslverr = 1'b0;
                n.bus = RCAL_BUS_IDLE;
            end
            default: begin
                // Unused code
                n.pready = 1'b0;
                n.pslverr = 1'b0;
                n.bus = RCAL_BUS_IDLE;
            end
        endcase

        // Lands at the edge ending DONE
        // Software wins over a roll-over in the same cycle
        if (commit) begin
            case (idx)
                `RCAL_IDX_MONTH: begin
                    // Locked: dropped
                    if (s.unlock) begin
                        n.month = pwdata[7:0];
                    end
                end
                `RCAL_IDX_YEAR: begin
                    // Locked: dropped
                    if (s.unlock) begin
                        n.year = pwdata[7:0];
                    end
                end
                `RCAL_IDX_HUNDRED: begin
                    // Locked: dropped
                    if (s.unlock) begin
                        n.hundred = pwdata[7:0];
                    end
                end
                `RCAL_IDX_WAKE_SEC: begin
                    // No lock here
                    n.wake_second = pwdata[7:0];
                end
                `RCAL_IDX_WAKE_MIN: begin
                    n.wake_minute = pwdata[7:0];
                end
                `RCAL_IDX_WAKE_HOUR: begin
                    n.wake_hour = pwdata[7:0];
                end
                `RCAL_IDX_CTRL: begin
                    // No conversion
                    n.unlock = pwdata[`RCAL_CTRL_UNLOCK];
                    n.decimal = pwdata[`RCAL_CTRL_DECIMAL];
                end
                `RCAL_IDX_MATCH_EN: begin
                    n.match_enable = pwdata[2:0];
                end
                default: begin
                    // Already an error
                    n.match_enable = s.match_enable;
                end
            endcase
        end

        // Only the bus answer and
        // control fields reset, so
        // counts survive mid-run
        // Counts and set-points are left alone by reset
        if (rst) begin
            n.bus = RCAL_BUS_IDLE;
            n.pready = 1'b0;
            n.pslverr = 1'b0;
            n.prdata = 32'h0000_0000;
            n.unlock = `RCAL_RST_UNLOCK;
            n.decimal = `RCAL_RST_DECIMAL;
            n.match_enable = `RCAL_RST_ENABLES;
            n.month = s.month;
            n.year = s.year;
            n.hundred = s.hundred;
            n.wake_second = s.wake_second;
            n.wake_minute = s.wake_minute;
            n.wake_hour = s.wake_hour;
        end
    end

    // All fields, every edge
    always_ff @(posedge mclk) begin
        s <= n;
    end

    // ****************************************************************
    // Alarm comparison
    // ****************************************************************
    // Own module: its flop
    // is the alarm_match port
    // Its reset clears the pulse
    rcal_alarm_cmp u_alarm (
        .mclk(mclk),
        .rst(rst),
        .count_tick(count_tick),
        .wake_second(s.wake_second),
        .wake_minute(s.wake_minute),
        .wake_hour(s.wake_hour),
        .match_enable(s.match_enable),
        .now_second(now_second),
        .now_minute(now_minute),
        .now_hour(now_hour),
        .alarm_match(alarm_match)
    );

    // ****************************************************************
    // Outputs, all straight from state flops
    // ****************************************************************
    // Each port is a state field
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign prdata = s.prdata;
    // Control fields
    assign decimal_mode = s.decimal;
    assign clock_unlock = s.unlock;
    assign match_enable = s.match_enable;
    // Live counts
    assign month_value = s.month;
    assign year_value = s.year;
    assign hundred_value = s.hundred;

endmodule : rcal_regs

// file: bench/rcal_regs_assertions.sv
// Checker for the calendar count and wake set-point register block.
// Assumes it is bound to rcal_regs and sees only that module's ports.
`timescale 1ns/1ps
`include "rcal_params.svh"

module rcal_regs_assertions (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`RCAL_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    // Calendar and alarm
    input wire logic month_carry,
    input wire logic count_tick,
    input wire logic decimal_mode,
    input wire logic clock_unlock,
    input wire logic [2:0] match_enable,
    input wire logic [7:0] month_value,
    input wire logic [7:0] year_value,
    input wire logic [7:0] hundred_value,
    input wire logic alarm_match
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    logic [7:0] idx;
    logic wr_done;
    logic [7:0] month_last;
    logic armed;
    assign idx = paddr[`RCAL_IDX_HI:`RCAL_IDX_LO];
    assign wr_done = psel && penable && pready && pwrite;
    assign month_last = decimal_mode ? 8'h12 : 8'h0c;

    // Counts are unknown until written, so the reset-keep check waits for an unlocked hundreds write
    always_ff @(posedge mclk) begin
        if (wr_done && clock_unlock && idx == `RCAL_IDX_HUNDRED) begin
            armed <= 1'b1;
        end
    end

    // ****************************************************************
    // Sequences
    // ****************************************************************
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_count_write(logic lk);
        wr_done && clock_unlock == lk && !month_carry
            && idx >= `RCAL_IDX_MONTH && idx <= `RCAL_IDX_HUNDRED;
    endsequence
    sequence s_carry(logic at_end);
        month_carry && !wr_done && ((month_value == month_last) == at_end);
    endsequence

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_ANSWER: assert property (s_access |=> pready ##1 !pready)
        else $error("access phase not answered in the next cycle");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("error response outside a completing cycle");
    AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read data bits not zero");
    AST_RESET_CTRL: assert property (disable iff (1'b0) rst |=>
        !clock_unlock && !decimal_mode && match_enable == 3'h0 && !alarm_match)
        else $error("control fields not cleared by reset");
    AST_LOCKED: assert property (s_count_write(1'b0) |=>
        $stable(month_value) && $stable(year_value) && $stable(hundred_value))
        else $error("locked count write took effect");
    AST_UNLOCKED: assert property (wr_done && clock_unlock && idx == `RCAL_IDX_MONTH |=>
        month_value == $past(pwdata[7:0]))
        else $error("unlocked month write lost");
    AST_MONTH_WRAP: assert property (s_carry(1'b1) |=> month_value == 8'h01)
        else $error("month did not wrap to one");
    AST_YEAR_HOLD: assert property (s_carry(1'b0) |=>
        $stable(year_value) && $stable(hundred_value))
        else $error("year moved without a month wrap");
    AST_MONTH_STEP: assert property (s_carry(1'b0) ##0 !decimal_mode |=>
        month_value == $past(month_value) + 8'h01)
        else $error("binary month did not step by one");
    AST_RESET_KEEP: assert property (disable iff (1'b0) rst && armed && !month_carry |=>
        $stable(month_value) && $stable(year_value) && $stable(hundred_value))
        else $error("reset altered a calendar count");
    AST_NO_ENABLE: assert property (count_tick && match_enable == 3'h0 |=> !alarm_match)
        else $error("alarm with no field enabled");
    AST_ALARM_CAUSE: assert property (alarm_match |->
        $past(count_tick) && $past(match_enable) != 3'h0)
        else $error("alarm without an enabled tick");
endmodule : rcal_regs_assertions

bind rcal_regs rcal_regs_assertions i_rcal_regs_assertions (
    .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .month_carry, .count_tick, .decimal_mode, .clock_unlock, .match_enable,
    .month_value, .year_value, .hundred_value, .alarm_match
);

// file: bench/rcal_regs_tb.sv
// Self-checking bench for the calendar count and wake set-point block.
// Assumes rcal_params.svh on the include path and the checker bound.
`timescale 1ns/1ps
`include "rcal_params.svh"

module rcal_regs_tb;
    localparam logic [7:0] K_MONTH = `RCAL_IDX_MONTH;
    localparam logic [7:0] K_YEAR = `RCAL_IDX_YEAR;
    localparam logic [7:0] K_HUND = `RCAL_IDX_HUNDRED;
    localparam logic [7:0] K_CTRL = `RCAL_IDX_CTRL;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pready, pslverr, decimal_mode, clock_unlock, alarm_match;
    logic [31:0] prdata;
    logic month_carry = 1'b0, count_tick = 1'b0;
    logic [7:0] now_second = 8'h00, now_minute = 8'h00, now_hour = 8'h00;
    logic [2:0] match_enable;
    logic [7:0] month_value, year_value, hundred_value, rd;
    logic err;
    int n_fail = 0, tests_run = 0;

    rcal_regs i_rcal_regs (
        .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
        .prdata, .month_carry, .count_tick, .now_second, .now_minute, .now_hour,
        .decimal_mode, .clock_unlock, .match_enable, .month_value, .year_value,
        .hundred_value, .alarm_match
    );

    initial begin
        forever #25 mclk = ~mclk;
    end

    // ****************************************************************
    // Common tasks
    // ****************************************************************
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check8

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int i;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge mclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            n_fail++;
            finish_test();
        end
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
        @(negedge mclk);
    endtask : wr

    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check8(rd, exp);
    endtask : rchk

    task automatic reset_pulse;
        @(posedge mclk);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
    endtask : reset_pulse

    task automatic carry;
        @(posedge mclk);
        month_carry <= 1'b1;
        @(posedge mclk);
        month_carry <= 1'b0;
    endtask : carry

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_lock;
        wr(K_CTRL, 8'h01);
        check8({7'h00, clock_unlock}, 8'h01);
        wr(K_MONTH, 8'h0c);
        wr(K_YEAR, 8'h63);
        wr(K_HUND, 8'h05);
        wr(K_CTRL, 8'h00);
        wr(K_MONTH, 8'h03);
        wr(K_YEAR, 8'h01);
        rchk(K_MONTH, 8'h0c);
        rchk(K_YEAR, 8'h63);
        rchk(K_HUND, 8'h05);
    endtask : t_lock

    // Binary wrap of month and year at their maxima
    task automatic t_roll_binary;
        carry();
        rchk(K_MONTH, 8'h01);
        rchk(K_YEAR, 8'h00);
        rchk(K_HUND, 8'h06);
        carry();
        rchk(K_MONTH, 8'h02);
        rchk(K_YEAR, 8'h00);
    endtask : t_roll_binary

    task automatic t_roll_decimal;
        wr(K_CTRL, 8'h03);
        wr(K_MONTH, 8'h12);
        wr(K_YEAR, 8'h99);
        wr(K_HUND, 8'h19);
        carry();
        rchk(K_MONTH, 8'h01);
        rchk(K_YEAR, 8'h00);
        rchk(K_HUND, 8'h20);
        wr(K_MONTH, 8'h09);
        carry();
        rchk(K_MONTH, 8'h10);
        rchk(K_YEAR, 8'h00);
    endtask : t_roll_decimal

    // Wake set-points are written while the counts are locked
    task automatic t_wake(input logic [7:0] ctl, input logic [7:0] s, m, h);
        wr(K_CTRL, ctl);
        wr(`RCAL_IDX_WAKE_SEC, s);
        wr(`RCAL_IDX_WAKE_MIN, m);
        wr(`RCAL_IDX_WAKE_HOUR, h);
        rchk(`RCAL_IDX_WAKE_SEC, s);
        rchk(`RCAL_IDX_WAKE_MIN, m);
        rchk(`RCAL_IDX_WAKE_HOUR, h);
    endtask : t_wake

    task automatic t_reset_keep;
        reset_pulse();
        check8({7'h00, clock_unlock}, 8'h00);
        check8({7'h00, decimal_mode}, 8'h00);
        rchk(`RCAL_IDX_MATCH_EN, 8'h00);
        rchk(`RCAL_IDX_WAKE_HOUR, 8'h23);
        rchk(K_MONTH, 8'h10);
        rchk(K_HUND, 8'h20);
        check8(month_value, 8'h10);
        check8(year_value, 8'h00);
        check8(hundred_value, 8'h20);
    endtask : t_reset_keep

    // Set-points hold 59:59:23; one tick with the given minute count
    task automatic t_tick(input logic [2:0] en, input logic [7:0] mn, input logic exp);
        wr(`RCAL_IDX_MATCH_EN, {5'h00, en});
        check8({5'h00, match_enable}, {5'h00, en});
        @(posedge mclk);
        now_second <= 8'h59;
        now_minute <= mn;
        now_hour <= 8'h23;
        count_tick <= 1'b1;
        @(posedge mclk);
        count_tick <= 1'b0;
        @(negedge mclk);
        check8({7'h00, alarm_match}, {7'h00, exp});
    endtask : t_tick

    task automatic t_unmapped;
        apb(1'b0, 8'h10, 8'h00);
        check8({7'h00, err}, 8'h01);
        apb(1'b1, 8'h10, 8'h55);
        check8({7'h00, err}, 8'h01);
        rchk(K_MONTH, 8'h10);
        check8({7'h00, err}, 8'h00);
    endtask : t_unmapped

    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        check8({5'h00, match_enable}, 8'h00);
        t_lock();
        t_roll_binary();
        t_roll_decimal();
        t_wake(8'h00, 8'h3b, 8'h3b, 8'h17);
        t_wake(8'h02, 8'h59, 8'h59, 8'h23);
        t_reset_keep();
        t_tick(3'h1, 8'h00, 1'b1);
        t_tick(3'h3, 8'h00, 1'b0);
        t_tick(3'h4, 8'h00, 1'b1);
        t_tick(3'h7, 8'h59, 1'b1);
        t_tick(3'h0, 8'h59, 1'b0);
        t_unmapped();
        finish_test();
    end
endmodule : rcal_regs_tb
